/* src/lce_pkg.sv */
// Constants, carriers and shared arithmetic of the line-cycle energy block.
package lce_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CF_MAX_HZ = 23_000;
    localparam int CF_HIGH_CYC = CLK_HZ / (2 * CF_MAX_HZ);
    localparam int SAMPLE_DIV = 4;
    localparam int PERIOD_DIV = 8;
    localparam int GAIN_SHIFT = 12;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_HALF = 8'h08;
    localparam logic [7:0] ADDR_NUM = 8'h0C;
    localparam logic [7:0] ADDR_DEN = 8'h10;
    localparam logic [7:0] ADDR_DIV = 8'h14;
    localparam logic [7:0] ADDR_GAIN = 8'h18;
    localparam logic [7:0] ADDR_PERIOD = 8'h1C;
    localparam logic [7:0] ADDR_ACT = 8'h20;
    localparam logic [7:0] ADDR_APP = 8'h24;
    localparam logic [7:0] ADDR_LACT = 8'h28;
    localparam logic [7:0] ADDR_LAPP = 8'h2C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_LINE_ACT_BIT = 0;
    localparam int CTRL_MASK_BIT = 1;
    localparam int STATUS_DONE_BIT = 0;
    localparam logic [11:0] RATIO_RESET = 12'h03F;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [11:0] GAIN_RESET = 12'h000;
    localparam logic [15:0] HALF_RESET = 16'hFFFF;
    localparam logic signed [25:0] FRAC_ONE = 26'sh1000000;

    // Register bus request, one cycle per access.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lce_bus_s;

    // Fractional accumulator and the energy step it released.
    typedef struct packed {
        logic signed [25:0] frac;
        logic signed [1:0] step;
    } lce_frac_s;

    // Adds one sample; a whole LSB leaving the fraction becomes a step.
    function automatic lce_frac_s lceAccStep(input logic signed [25:0] frac,
                                             input logic signed [24:0] add);
        lce_frac_s r;
        logic signed [25:0] sum;
        sum = frac + {add[24], add};
        r.frac = sum;
        r.step = 2'sb00;
        if (sum >= FRAC_ONE)
        begin
            r.frac = sum - FRAC_ONE;
            r.step = 2'sb01;
        end
        else if (sum <= -FRAC_ONE)
        begin
            r.frac = sum + FRAC_ONE;
            r.step = 2'sb11;
        end
        return r;
    endfunction

endpackage

/* src/lce_period_meter.sv */
// Zero-crossing detector and line period meter.
`timescale 1ns/1ps
`default_nettype none
module lce_period_meter
    import lce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic lineSign,
    output logic halfCross,
    output logic [15:0] periodOut
);
    typedef struct packed {
        logic signDly;
        logic [2:0] pre;
        logic [15:0] cnt;
        logic half;
        logic [15:0] period;
    } lce_pm_s;

    lce_pm_s s_reg;
    lce_pm_s s_next;

    // ------------------------------------------------------------------
    // Crossing detection and period count in units of eight clocks
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.signDly = lineSign;
        s_next.half = lineSign ^ s_reg.signDly;
        if (s_reg.pre == 3'(PERIOD_DIV - 1))
        begin
            s_next.pre = 3'h0;
            // Saturate so a stalled line never wraps to a short period.
            if (s_reg.cnt != 16'hFFFF)
                s_next.cnt = s_reg.cnt + 16'h0001;
        end
        else
            s_next.pre = s_reg.pre + 3'h1;
        if (lineSign && !s_reg.signDly)
        begin
            // Include a unit that completes on this very edge, else the period reads one short.
            s_next.period = s_next.cnt;
            s_next.cnt = 16'h0000;
            s_next.pre = 3'h0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end

    assign halfCross = s_reg.half;
    assign periodOut = s_reg.period;
endmodule // lce_period_meter
`default_nettype wire

/* src/lce_pulse_gen.sv */
// Calibration pulse generator scaled by a numerator over a denominator.
`timescale 1ns/1ps
`default_nettype none
module lce_pulse_gen
    import lce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic stepIn,
    input wire logic [11:0] num,
    input wire logic [11:0] den,
    output logic cfOut
);
    typedef struct packed {
        logic [15:0] acc;
        logic [7:0] pend;
        logic [10:0] timer;
        logic cf;
    } lce_pg_s;

    lce_pg_s s_reg;
    lce_pg_s s_next;
    logic [15:0] denOne;

    // ------------------------------------------------------------------
    // Rate scaling and pulse shaping
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        denOne = {4'h0, den} + 16'h0001;
        if (stepIn)
            s_next.acc = s_reg.acc + {4'h0, num} + 16'h0001;
        if (s_next.acc >= denOne)
        begin
            s_next.acc = s_next.acc - denOne;
            if (s_reg.pend != 8'hFF)
                s_next.pend = s_reg.pend + 8'h01;
        end
        if (s_reg.timer != 11'h000)
            s_next.timer = s_reg.timer - 11'h001;
        else if (s_next.pend != 8'h00)
        begin
            s_next.pend = s_next.pend - 8'h01;
            s_next.timer = 11'(2 * CF_HIGH_CYC - 1);
        end
        s_next.cf = s_next.timer >= 11'(CF_HIGH_CYC);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end

    assign cfOut = s_reg.cf;
endmodule // lce_pulse_gen
`default_nettype wire

/* src/lce_top.sv */
// Line-cycle energy accumulation and calibration pulse block.
//
// Overview of operation
// - Apparent energy summed over whole half cycles.
// - Apparent line accumulation always on.
// - Window length is 16-bit half-cycle count.
// - Active and apparent share one window.
// - Window end sets the cycle done flag.
// - Masked flag drives active-low interrupt.
// - Line apparent uses continuous apparent path.
// - Pulse output from active energy only.
// - Pulse rate scaled by (num+1)/(den+1).
// - Divider resets zero, skips pulse chain.
// - Gain scales active energy and pulses alike.
// - Period measured in eight-clock units.
// - Window time is count times period/2.
// - Numerator and denominator reset to 0x3F.
// - Undivided pulse rate tops at 23 kHz.
// - No reactive gain or offset adjustment.
`timescale 1ns/1ps
`default_nettype none
module lce_top
    import lce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire lce_bus_s busIn,
    output logic [31:0] rdata,
    input wire logic signed [23:0] activePower,
    input wire logic [23:0] apparentPower,
    input wire logic lineSign,
    output logic cfOut,
    output logic irqOut,
    output logic irqOeN
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rdata;
        logic lineActEn;
        logic doneMask;
        logic cycleDone;
        logic [15:0] halfCount;
        logic [11:0] num;
        logic [11:0] den;
        logic [7:0] div;
        logic [11:0] gain;
        logic [1:0] phase;
        logic signed [25:0] actFrac;
        logic signed [25:0] appFrac;
        logic signed [8:0] divCnt;
        logic [23:0] actTotal;
        logic [23:0] appTotal;
        logic [23:0] lineAct;
        logic [23:0] lineApp;
        logic [23:0] accAct;
        logic [23:0] accApp;
        logic [15:0] halfSeen;
        logic cfStep;
        logic irqOeN;
    } lce_top_s;

    lce_top_s s_reg;
    lce_top_s s_next;

    // Helper nets of the combinational process.
    logic tick;
    logic halfCross;
    logic [15:0] period;
    logic signed [35:0] gainProd;
    logic signed [24:0] actScaled;
    lce_frac_s actRes;
    lce_frac_s appRes;
    logic signed [1:0] actStep;
    logic signed [8:0] divEff;
    logic [15:0] halfTarget;
    logic windowEnd;

    // ------------------------------------------------------------------
    // Line period and zero crossings
    // ------------------------------------------------------------------
    lce_period_meter u_period
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .lineSign(lineSign),
        .halfCross(halfCross),
        .periodOut(period)
    );

    // ------------------------------------------------------------------
    // Calibration pulse chain
    // ------------------------------------------------------------------
    // active energy only
    lce_pulse_gen u_pulse
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .stepIn(s_reg.cfStep),
        .num(s_reg.num),
        .den(s_reg.den),
        .cfOut(cfOut)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Samples are taken once every four clocks; all arithmetic of a
    // sample is done in that one cycle, so no pipeline skew can split
    // a step between a closing window and the next one.
    always_comb
    begin
        s_next = s_reg;
        tick = s_reg.phase == 2'(SAMPLE_DIV - 1);
        s_next.phase = s_reg.phase + 2'h1;
        s_next.cfStep = 1'b0;

        gainProd = activePower * $signed(s_reg.gain);
        actScaled = {activePower[23], activePower}
                  + {gainProd[35], gainProd[35:12]};

        actRes = lceAccStep(s_reg.actFrac, actScaled);
        appRes = lceAccStep(s_reg.appFrac, {1'b0, apparentPower});
        actStep = 2'sb00;

        // divider of zero acts as one
        divEff = (s_reg.div == 8'h00) ? 9'sd1 : $signed({1'b0, s_reg.div});

        if (tick)
        begin
            s_next.actFrac = actRes.frac;
            s_next.appFrac = appRes.frac;
            s_next.cfStep = actRes.step == 2'sb01;
            if (actRes.step == 2'sb01)
            begin
                if (s_reg.divCnt + 9'sd1 >= divEff)
                begin
                    s_next.divCnt = 9'sd0;
                    actStep = 2'sb01;
                end
                else
                    s_next.divCnt = s_reg.divCnt + 9'sd1;
            end
            else if (actRes.step == 2'sb11)
            begin
                if (s_reg.divCnt - 9'sd1 <= -divEff)
                begin
                    s_next.divCnt = 9'sd0;
                    actStep = 2'sb11;
                end
                else
                    s_next.divCnt = s_reg.divCnt - 9'sd1;
            end
            if (appRes.step == 2'sb01)
            begin
                s_next.appTotal = s_reg.appTotal + 24'h000001;
                s_next.accApp = s_reg.accApp + 24'h000001;
            end
            else if (appRes.step == 2'sb11)
            begin
                s_next.appTotal = s_reg.appTotal - 24'h000001;
                s_next.accApp = s_reg.accApp - 24'h000001;
            end
        end

        // Divided active steps feed both the total and the line window.
        if (actStep == 2'sb01)
        begin
            s_next.actTotal = s_reg.actTotal + 24'h000001;
            if (s_reg.lineActEn)
                s_next.accAct = s_reg.accAct + 24'h000001;
        end
        else if (actStep == 2'sb11)
        begin
            s_next.actTotal = s_reg.actTotal - 24'h000001;
            if (s_reg.lineActEn)
                s_next.accAct = s_reg.accAct - 24'h000001;
        end

        halfTarget = (s_reg.halfCount == 16'h0000) ? 16'h0001 : s_reg.halfCount;
        windowEnd = 1'b0;
        if (halfCross)
        begin
            if (s_reg.halfSeen + 16'h0001 >= halfTarget)
            begin
                windowEnd = 1'b1;
                s_next.halfSeen = 16'h0000;
            end
            else
                s_next.halfSeen = s_reg.halfSeen + 16'h0001;
        end

        // ------------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------------
        if (busIn.wr)
        begin
            unique case (busIn.addr)
                ADDR_CTRL:
                begin
                    s_next.lineActEn = busIn.wdata[CTRL_LINE_ACT_BIT];
                    s_next.doneMask = busIn.wdata[CTRL_MASK_BIT];
                end
                ADDR_STATUS:
                begin
                    if (busIn.wdata[STATUS_DONE_BIT])
                        s_next.cycleDone = 1'b0;
                end
                ADDR_HALF:
                begin
                    s_next.halfCount = busIn.wdata[15:0];
                end
                ADDR_NUM:
                begin
                    s_next.num = busIn.wdata[11:0];
                end
                ADDR_DEN:
                begin
                    s_next.den = busIn.wdata[11:0];
                end
                ADDR_DIV:
                begin
                    s_next.div = busIn.wdata[7:0];
                end
                ADDR_GAIN:
                begin
                    s_next.gain = busIn.wdata[11:0];
                end
                default:
                begin
                    s_next.rdata = s_next.rdata;
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Window close, applied after writes so the flag set wins
        // ------------------------------------------------------------------
        if (windowEnd)
        begin
            if (s_reg.lineActEn)
                s_next.lineAct = s_next.accAct;
            s_next.lineApp = s_next.accApp;
            s_next.accAct = 24'h000000;
            s_next.accApp = 24'h000000;
            s_next.cycleDone = 1'b1;
        end

        s_next.irqOeN = !(s_next.cycleDone && s_next.doneMask);

        // ------------------------------------------------------------------
        // Register reads, answered in the next cycle
        // ------------------------------------------------------------------
        s_next.rdata = 32'h00000000;
        if (busIn.rd)
        begin
            unique case (busIn.addr)
                ADDR_CTRL:
                begin
                    s_next.rdata[CTRL_LINE_ACT_BIT] = s_reg.lineActEn;
                    s_next.rdata[CTRL_MASK_BIT] = s_reg.doneMask;
                end
                ADDR_STATUS:
                begin
                    s_next.rdata[STATUS_DONE_BIT] = s_reg.cycleDone;
                end
                ADDR_HALF:
                begin
                    s_next.rdata[15:0] = s_reg.halfCount;
                end
                ADDR_NUM:
                begin
                    s_next.rdata[11:0] = s_reg.num;
                end
                ADDR_DEN:
                begin
                    s_next.rdata[11:0] = s_reg.den;
                end
                ADDR_DIV:
                begin
                    s_next.rdata[7:0] = s_reg.div;
                end
                ADDR_GAIN:
                begin
                    s_next.rdata[11:0] = s_reg.gain;
                end
                ADDR_PERIOD:
                begin
                    s_next.rdata[15:0] = period;
                end
                ADDR_ACT:
                begin
                    s_next.rdata[23:0] = s_reg.actTotal;
                end
                ADDR_APP:
                begin
                    s_next.rdata[23:0] = s_reg.appTotal;
                end
                ADDR_LACT:
                begin
                    s_next.rdata[23:0] = s_reg.lineAct;
                end
                ADDR_LAPP:
                begin
                    s_next.rdata[23:0] = s_reg.lineApp;
                end
                // Unmapped addresses read as zero.
                default:
                begin
                    s_next.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.num <= RATIO_RESET;
            s_reg.den <= RATIO_RESET;
            s_reg.div <= DIV_RESET;
            s_reg.gain <= GAIN_RESET;
            s_reg.halfCount <= HALF_RESET;
            s_reg.irqOeN <= 1'b1;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The interrupt pin only sinks, so its data bit is a constant low.
    assign rdata = s_reg.rdata;
    assign irqOut = 1'b0;
    assign irqOeN = s_reg.irqOeN;

endmodule // lce_top
`default_nettype wire

/* test/lce_checker.sv */
// Port-level assertions for the line-cycle energy block.
`timescale 1ns/1ps
`default_nettype none
module lce_checker
    import lce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire lce_bus_s busIn,
    input wire logic [31:0] rdata,
    input wire logic cfOut,
    input wire logic irqOut,
    input wire logic irqOeN
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------
    // Shadows
    // ------------
    logic [11:0] numReg;
    logic [11:0] denReg;
    logic [15:0] halfReg;
    logic maskReg;
    logic [15:0] hiCnt;
    logic [15:0] loCnt;
    logic pulsedReg;
    logic wrHit;
    assign wrHit = ce && busIn.wr;

    // Settings rebuilt from bus writes; the low counter saturates so a long idle never wraps.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            numReg <= RATIO_RESET;
            denReg <= RATIO_RESET;
            halfReg <= HALF_RESET;
            maskReg <= 1'b0;
            hiCnt <= 16'h0;
            loCnt <= 16'h0;
            pulsedReg <= 1'b0;
        end
        // Shadows freeze with the block, so a stalled pulse is not mistaken for a long one.
        else if (ce)
        begin
            if (wrHit && busIn.addr == ADDR_NUM)
                numReg <= busIn.wdata[11:0];
            if (wrHit && busIn.addr == ADDR_DEN)
                denReg <= busIn.wdata[11:0];
            if (wrHit && busIn.addr == ADDR_HALF)
                halfReg <= busIn.wdata[15:0];
            if (wrHit && busIn.addr == ADDR_CTRL)
                maskReg <= busIn.wdata[CTRL_MASK_BIT];
            hiCnt <= cfOut ? hiCnt + 16'h1 : 16'h0;
            loCnt <= cfOut ? 16'h0 : loCnt + {15'h0, loCnt != 16'hFFFF};
            pulsedReg <= pulsedReg | (hiCnt != 16'h0 && !cfOut);
        end
    end

    // ------------
    // Properties
    // ------------
    sequence s_rd(logic [7:0] a);
        ce && busIn.rd && busIn.addr == a;
    endsequence
    property p_irqLevel;
        irqOut == 1'b0;
    endproperty
    property p_irqMask;
        !irqOeN |-> (maskReg || $past(maskReg));
    endproperty
    property p_cfHigh;
        $fell(cfOut) |-> hiCnt == CF_HIGH_CYC;
    endproperty
    property p_cfGap;
        $rose(cfOut) && pulsedReg |-> loCnt >= CF_HIGH_CYC;
    endproperty
    property p_num;
        s_rd(ADDR_NUM) |=> rdata == {20'h0, numReg};
    endproperty
    property p_den;
        s_rd(ADDR_DEN) |=> rdata == {20'h0, denReg};
    endproperty
    property p_half;
        s_rd(ADDR_HALF) |=> rdata == {16'h0, halfReg};
    endproperty
    property p_status;
        s_rd(ADDR_STATUS) ##0 !irqOeN |=> rdata[STATUS_DONE_BIT];
    endproperty

    a_irqLevel: assert property (p_irqLevel) else $error("irq data not low");
    a_irqMask: assert property (p_irqMask) else $error("irq while masked");
    a_cfHigh: assert property (p_cfHigh) else $error("pulse width wrong");
    a_cfGap: assert property (p_cfGap) else $error("pulse gap too short");
    a_num: assert property (p_num) else $error("numerator readback wrong");
    a_den: assert property (p_den) else $error("denominator readback wrong");
    a_half: assert property (p_half) else $error("half count readback wrong");
    a_status: assert property (p_status) else $error("done flag not set");
endmodule // lce_checker

bind lce_top lce_checker chk_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .busIn(busIn),
    .rdata(rdata), .cfOut(cfOut), .irqOut(irqOut), .irqOeN(irqOeN));
`default_nettype wire

/* test/lce_host_model.sv */
// Host model that reaches the registers and notes expected read data.
`timescale 1ns/1ps
`default_nettype none
module lce_host_model
    import lce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic irqOeN,
    output var lce_bus_s busOut
);
    logic [31:0] expQ[$];
    logic [31:0] tolQ[$];

    initial busOut = '0;

    // One-cycle write strobe, released at the following edge.
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        busOut <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        busOut <= '0;
    endtask

    // One-cycle read strobe; the answer is checked by the bench monitor.
    task automatic regRead(input logic [7:0] a, input logic [31:0] e, input logic [31:0] t);
        @(posedge ref_clk);
        busOut <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        expQ.push_back(e);
        tolQ.push_back(t);
        @(posedge ref_clk);
        busOut <= '0;
    endtask

    task automatic window(input logic [31:0] act, input logic [31:0] app, input logic [31:0] t);
        for (int n = 0; n < 2; n++)
        begin
            regWrite(ADDR_STATUS, 32'h1);
            repeat (2) @(posedge ref_clk);
            for (int i = 0; i < 4000 && irqOeN !== 1'b0; i++)
                @(posedge ref_clk);
        end
        regRead(ADDR_LACT, act, t);
        regRead(ADDR_LAPP, app, t);
    endtask
endmodule // lce_host_model
`default_nettype wire

/* test/tb_line_cycle_energy_calibration.sv */
// Self-checking bench for the line-cycle energy block.
`timescale 1ns/1ps
`default_nettype none
module tb_line_cycle_energy_calibration;
    import lce_pkg::*;
    localparam int HALF_CYC = 400;
    localparam int LIMIT = 60000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic signed [23:0] activePower = 24'sh400000;
    logic [23:0] apparentPower = 24'h800000;
    logic lineSign = 1'b0;
    lce_bus_s busIn;
    logic [31:0] rdata;
    logic cfOut;
    logic irqOut;
    logic irqOeN;
    logic rdSeen = 1'b0;
    logic cfPrev = 1'b0;
    logic [31:0] riseCnt = 32'h0;
    logic [31:0] startCnt;
    logic [31:0] expV;
    logic [31:0] tolV;
    logic [7:0] seed = 8'h26;
    int lineCnt = 0;
    int cycCnt = 0;
    int errTotal = 0;
    int cmpCount = 0;
    logic [7:0] rstAddr [8] = '{ADDR_CTRL, ADDR_STATUS, ADDR_HALF, ADDR_NUM,
        ADDR_DEN, ADDR_DIV, ADDR_GAIN, 8'h30};
    logic [31:0] rstVal [8] = '{32'h0, 32'h0, 32'hFFFF, 32'h3F, 32'h3F, 32'h0, 32'h0, 32'h0};

    always #20 ref_clk = ~ref_clk;

    lce_top dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .busIn(busIn), .rdata(rdata),
        .activePower(activePower), .apparentPower(apparentPower), .lineSign(lineSign),
        .cfOut(cfOut), .irqOut(irqOut), .irqOeN(irqOeN));
    lce_host_model host_u (.ref_clk(ref_clk), .irqOeN(irqOeN), .busOut(busIn));

    // ------------
    // Helpers
    // ------------
    function automatic logic [7:0] lfsrNext(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Returns the expectation when the seen value is within tolerance, so X never matches.
    function automatic logic [31:0] near(input logic [31:0] s, e, t);
        return (s + t >= e && s <= e + t) ? e : s;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic completeRun;
        $display("checks %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Line source: a crossing every HALF_CYC clocks, so a full period is 800 clocks.
    always @(posedge ref_clk)
    begin
        lineCnt <= (lineCnt == HALF_CYC - 1) ? 0 : lineCnt + 1;
        if (lineCnt == HALF_CYC - 1)
            lineSign <= !lineSign;
    end

    // Monitor: read data stand only in the cycle after the strobe.
    always @(posedge ref_clk)
    begin
        rdSeen <= ce && busIn.rd;
        cfPrev <= cfOut;
        if (cfOut && !cfPrev)
            riseCnt <= riseCnt + 32'h1;
        if (rdSeen)
        begin
            tolV = host_u.tolQ.pop_front();
            expV = host_u.expQ.pop_front();
            check("rdata", near(rdata, expV, tolV), expV);
        end
        cycCnt <= cycCnt + 1;
        if (cycCnt == LIMIT)
        begin
            errTotal++;
            completeRun();
        end
    end

    // ------------
    // Scenarios
    // ------------
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            host_u.regRead(rstAddr[i], rstVal[i], 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsrNext(seed);
            host_u.regWrite(i[0] ? ADDR_DEN : ADDR_NUM, {24'h0, seed});
            host_u.regRead(i[0] ? ADDR_DEN : ADDR_NUM, {24'h0, seed}, 32'h0);
        end
        host_u.regWrite(ADDR_PERIOD, 32'h1234);
        host_u.regWrite(ADDR_HALF, 32'h2);
        host_u.regWrite(ADDR_CTRL, 32'h1);
        repeat (2000) @(posedge ref_clk);
        check("irqOeN", {31'h0, irqOeN}, 32'h1);
        host_u.regRead(ADDR_STATUS, 32'h1, 32'h0);
        host_u.regWrite(ADDR_CTRL, 32'h3);
        host_u.window(32'd50, 32'd100, 32'h1);
        check("irqOeN", {31'h0, irqOeN}, 32'h0);
        host_u.regRead(ADDR_STATUS, 32'h1, 32'h0);
        host_u.regRead(ADDR_PERIOD, 32'd100, 32'h0);
        host_u.regWrite(ADDR_GAIN, 32'h800);
        host_u.regWrite(ADDR_DIV, 32'h2);
        host_u.window(32'd12, 32'd100, 32'h1);
        host_u.regWrite(ADDR_CTRL, 32'h2);
        host_u.window(32'd12, 32'd100, 32'h1);
        // A write made while the clock enable is low must be dropped.
        ce <= 1'b0;
        host_u.regWrite(ADDR_DIV, 32'h5);
        ce <= 1'b1;
        host_u.regRead(ADDR_DIV, 32'h2, 32'h0);
        // Second reset, then pulse scaling with a slow active source.
        rst <= 1'b1;
        activePower <= 24'sh008000;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        host_u.regWrite(ADDR_NUM, 32'h0);
        host_u.regWrite(ADDR_DEN, 32'h1);
        host_u.regWrite(ADDR_DIV, 32'h3);
        startCnt = riseCnt;
        repeat (20480) @(posedge ref_clk);
        check("pulses", near(riseCnt - startCnt, 32'd5, 32'h1), 32'd5);
        host_u.regRead(ADDR_ACT, 32'd3, 32'h1);
        host_u.regRead(ADDR_APP, 32'd2561, 32'h2);
        activePower <= -24'sh008000;
        repeat (1100) @(posedge ref_clk);
        startCnt = riseCnt;
        repeat (8192) @(posedge ref_clk);
        check("negPulses", riseCnt - startCnt, 32'h0);
        completeRun();
    end
endmodule // tb_line_cycle_energy_calibration
`default_nettype wire
